// *** hw/dpl_defs.svh ***
// Constants of the DPLL phase lock and phase loss detector.
// Assumes a 10 MHz system clock and an 8-bit register port.
`ifndef DPL_DEFS_SVH
`define DPL_DEFS_SVH

// ==========================================
// Register offsets
`define DPL_OFS_FINE      8'h73
`define DPL_OFS_COARSE    8'h74
`define DPL_OFS_STAT      8'h75
`define DPL_OFS_MASK      8'h76
`define DPL_OFS_STATE     8'h77

// ==========================================
// Reset values and field layout
`define DPL_FINE_RST      8'hA2
`define DPL_COARSE_RST    8'h85
`define DPL_FINE_WMASK    8'hE7
`define DPL_COARSE_WMASK  8'hEF
`define DPL_EN_BIT        7
`define DPL_EV_LOCK       0
`define DPL_EV_FINE       1
`define DPL_EV_COARSE     2

// ==========================================
// Widths and timing
`define DPL_FRAC_W        12
`define DPL_UI_W          8
`define DPL_FINE_STEP     512
`define DPL_CLK_HZ        10000000
`define DPL_TICK_US       1000
`define DPL_QUAL_MS       1000
`define DPL_TICK_CYC      (`DPL_TICK_US * (`DPL_CLK_HZ / 1000000))
`define DPL_QUAL_TICKS    ((`DPL_QUAL_MS * 1000) / `DPL_TICK_US)

`endif

// *** hw/dpl_pkg.sv ***
// Types of the DPLL phase lock and phase loss detector.
// Assumes the constants header is on the include path.
`include "dpl_defs.svh"

package dpl_pkg;

    // ==========================================
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dpl_bus_t;

    // ==========================================
    // Phase detector sample from the loop
    typedef struct packed {
        logic                          valid;
        logic signed [`DPL_FRAC_W-1:0] frac;
        logic [`DPL_UI_W-1:0]          ui;
    } dpl_phase_t;

    // ==========================================
    // Lock state machine, one-hot
    typedef enum logic [2:0] {
        DPL_UNLOCKED = 3'h1,
        DPL_QUALIFY  = 3'h2,
        DPL_LOCKED   = 3'h4
    } dpl_fsm_t;

    // ==========================================
    // Whole state of the detector
    typedef struct packed {
        logic [7:0]  fine;
        logic [7:0]  coarse;
        logic [2:0]  stat;
        logic [2:0]  mask;
        dpl_fsm_t    st;
        logic [23:0] tick;
        logic [15:0] qual;
        logic        inwin;
        logic        over;
        logic        fine_loss;
        logic        coarse_loss;
        logic        lock;
        logic        loss;
        logic        irq;
        logic [7:0]  rdata;
    } dpl_state_t;

endpackage

// *** hw/dpl_lock_detect.sv ***
// Phase lock and phase loss detector of the output DPLL.
// Assumes phase samples come from loop logic on mclk,
// and a register master that never issues read and write together.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "dpl_defs.svh"

module dpl_lock_detect #(
    parameter logic [23:0] TICK_CYC   = 24'(`DPL_TICK_CYC),
    parameter logic [15:0] QUAL_TICKS = 16'(`DPL_QUAL_TICKS),
    parameter logic [11:0] FINE_STEP  = 12'(`DPL_FINE_STEP)
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  dpl_pkg::dpl_bus_t   bus,
    input  dpl_pkg::dpl_phase_t phase,
    output logic [7:0]          rdata,
    output logic                phase_lock,
    output logic                phase_loss,
    output logic                irq
);
    import dpl_pkg::*;

    // ==========================================
    // Reset image of the whole state
    localparam dpl_state_t RST_STATE = '{
        fine:        `DPL_FINE_RST,
        coarse:      `DPL_COARSE_RST,
        stat:        3'h0,
        mask:        3'h0,
        st:          DPL_UNLOCKED,
        tick:        24'h000000,
        qual:        16'h0000,
        inwin:       1'b0,
        over:        1'b0,
        fine_loss:   1'b0,
        coarse_loss: 1'b0,
        lock:        1'b0,
        loss:        1'b0,
        irq:         1'b0,
        rdata:       8'h00
    };

    dpl_state_t q;
    dpl_state_t d;
    logic       tick_p;
    logic [2:0] ev;
    logic [2:0] clr;
    logic       stat_wr;

    // ==========================================
    // Helpers

    // Magnitude of a signed fraction; the most negative value still fits unsigned
    function automatic logic [`DPL_FRAC_W-1:0] abs_mag(
        input logic signed [`DPL_FRAC_W-1:0] v
    );
        abs_mag = v[`DPL_FRAC_W-1] ? -v : v;
    endfunction

    // Window half-width grows linearly with the code
    function automatic logic [15:0] win_limit(
        input logic [2:0] code
    );
        win_limit = 16'(code) * 16'(FINE_STEP);
    endfunction

    // Code 000 gives a zero window, so almost every sample is outside
    function automatic logic in_window(
        input logic signed [`DPL_FRAC_W-1:0] v,
        input logic [2:0]                    code
    );
        in_window = 16'(abs_mag(v)) <= win_limit(code);
    endfunction

    // Read multiplexer; unmapped offsets read as zero
    function automatic logic [7:0] read_mux(
        input logic [7:0] a,
        input dpl_state_t s
    );
        case (a)
            `DPL_OFS_FINE:   read_mux = s.fine;
            `DPL_OFS_COARSE: read_mux = s.coarse;
            `DPL_OFS_STAT:   read_mux = {5'h00, s.stat};
            `DPL_OFS_MASK:   read_mux = {5'h00, s.mask};
            `DPL_OFS_STATE:  read_mux = {4'h0, s.coarse_loss, s.fine_loss, s.loss, s.lock};
            default:         read_mux = 8'h00;
        endcase
    endfunction

    // ==========================================
    // Next state
    always_comb begin
        d       = q;
        tick_p  = 1'b0;
        ev      = 3'h0;
        clr     = 3'h0;
        stat_wr = 1'b0;

        // Millisecond tick; slow counting runs on this enable, not a second clock
        if (q.tick >= TICK_CYC - 24'h000001) begin
            d.tick = 24'h000000;
            tick_p = 1'b1;
        end else begin
            d.tick = q.tick + 24'h000001;
        end

        // Configuration writes; fine bits 4:3 and coarse bit 4 are dropped so they read as zero
        if (bus.wr) begin
            case (bus.addr)
                `DPL_OFS_FINE: begin
                    d.fine = bus.wdata & `DPL_FINE_WMASK;
                end
                `DPL_OFS_COARSE: begin
                    d.coarse = bus.wdata & `DPL_COARSE_WMASK;
                end
                `DPL_OFS_STAT: begin
                    stat_wr = 1'b1;
                end
                `DPL_OFS_MASK: begin
                    d.mask = bus.wdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // Each sample refreshes the held comparison results
        if (phase.valid) begin
            d.inwin = in_window(phase.frac, q.fine[2:0]);
            d.over  = phase.ui > {4'h0, q.coarse[3:0]};
        end

        // Fine loss only when enabled; no qualification delay
        d.fine_loss = q.fine[`DPL_EN_BIT] & ~d.inwin;

        // Coarse loss compares whole cycles against the limit
        d.coarse_loss = q.coarse[`DPL_EN_BIT] & d.over;

        // With fine detection off, only the coarse result decides loss
        d.loss = d.fine_loss | d.coarse_loss;

        // Lock qualification
        case (q.st)
            DPL_UNLOCKED: begin
                if (d.inwin && !d.loss) begin
                    d.st   = DPL_QUALIFY;
                    d.qual = 16'h0000;
                    d.tick = 24'h000000; // Full first tick keeps the wait at least a second
                end
            end
            DPL_QUALIFY: begin
                if (!d.inwin || d.loss) begin
                    d.st = DPL_UNLOCKED;
                end else if (tick_p) begin
                    if (q.qual >= QUAL_TICKS - 16'h0001) begin
                        d.st = DPL_LOCKED;
                    end else begin
                        d.qual = q.qual + 16'h0001;
                    end
                end
            end
            DPL_LOCKED: begin
                if (!d.inwin || d.loss) begin
                    d.st = DPL_UNLOCKED;
                end
            end
            default: begin
                d.st = DPL_UNLOCKED;
            end
        endcase

        d.lock = (d.st == DPL_LOCKED);

        // Rising edges of lock and of each loss source are the events
        ev[`DPL_EV_LOCK]   = d.lock & ~q.lock;
        ev[`DPL_EV_FINE]   = d.fine_loss & ~q.fine_loss;
        ev[`DPL_EV_COARSE] = d.coarse_loss & ~q.coarse_loss;

        // Write one to clear; a new event in the same cycle wins
        if (stat_wr) begin
            clr = bus.wdata[2:0];
        end
        d.stat = (q.stat & ~clr) | ev;

        // Level interrupt while any unmasked status bit is set
        d.irq = |(d.stat & d.mask);

        // Read data stands only in the cycle after the strobe
        d.rdata = bus.rd ? read_mux(bus.addr, q) : 8'h00;
    end

    // ==========================================
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Outputs, all straight from the state register
    assign rdata      = q.rdata;
    assign phase_lock = q.lock;
    assign phase_loss = q.loss;
    assign irq        = q.irq;

endmodule

// *** sim/dpl_lock_detect_properties.sv ***
// Checker for the phase lock and loss detector, bound to its top ports.
// Assumes the register map header and one mclk domain.
`timescale 1ns/1ps
`include "dpl_defs.svh"
module dpl_lock_detect_properties
    import dpl_pkg::*;
#(
    parameter logic [23:0] TICK_CYC   = 24'(`DPL_TICK_CYC),
    parameter logic [15:0] QUAL_TICKS = 16'(`DPL_QUAL_TICKS),
    parameter logic [11:0] FINE_STEP  = 12'(`DPL_FINE_STEP)
) (
    input wire logic          mclk,
    input wire logic          rst,
    input dpl_pkg::dpl_bus_t   bus,
    input dpl_pkg::dpl_phase_t phase,
    input wire logic [7:0]    rdata,
    input wire logic          phase_lock,
    input wire logic          phase_loss,
    input wire logic          irq
);
    // ==========================================
    // Shadow of the config registers, kept from the bus traffic
    logic [7:0]  fine_q;
    logic [7:0]  coarse_q;
    logic [2:0]  mask_q;
    logic [31:0] quiet_q;
    logic [12:0] mag;
    logic [14:0] win;
    always_ff @(posedge mclk) begin
        if (rst) begin
            fine_q   <= `DPL_FINE_RST;
            coarse_q <= `DPL_COARSE_RST;
            mask_q   <= 3'h0;
            quiet_q  <= 32'h0;
        end else begin
            if (bus.wr && bus.addr == `DPL_OFS_FINE) fine_q <= bus.wdata & `DPL_FINE_WMASK;
            if (bus.wr && bus.addr == `DPL_OFS_COARSE) coarse_q <= bus.wdata & `DPL_COARSE_WMASK;
            if (bus.wr && bus.addr == `DPL_OFS_MASK) mask_q <= bus.wdata[2:0];
            quiet_q  <= phase_loss ? 32'h0 : quiet_q + 32'h1;
        end
    end
    // Magnitude kept one bit wider so the most negative error does not wrap
    assign mag = phase.frac[11] ? 13'(~{phase.frac[11], phase.frac} + 13'h1) : {1'b0, phase.frac};
    assign win = 15'(fine_q[2:0]) * 15'(FINE_STEP);

    // ==========================================
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_fine_loss_now: assert property (phase.valid && fine_q[7] && {2'h0, mag} > win |=> phase_loss)
        else $error("fine loss missing");
    a_coarse_loss_now: assert property (
        phase.valid && coarse_q[7] && phase.ui > {4'h0, coarse_q[3:0]} |=> phase_loss)
        else $error("coarse loss missing");
    a_quiet_sample: assert property (phase.valid && (!fine_q[7] || {2'h0, mag} <= win)
        && (!coarse_q[7] || phase.ui <= {4'h0, coarse_q[3:0]}) |=> !phase_loss)
        else $error("loss without cause");
    a_loss_drops_lock: assert property (phase_loss |-> !phase_lock)
        else $error("lock held during loss");
    a_lock_qualified: assert property ($rose(phase_lock) |-> quiet_q >= 32'((QUAL_TICKS - 1) * TICK_CYC))
        else $error("lock without qualification");
    a_read_fine: assert property (bus.rd && bus.addr == `DPL_OFS_FINE |=> rdata == fine_q)
        else $error("fine read wrong");
    a_read_coarse: assert property (bus.rd && bus.addr == `DPL_OFS_COARSE |=> rdata == coarse_q)
        else $error("coarse read wrong");
    a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("read data outside read");
    a_irq_masked: assert property (mask_q == 3'h0 && !(bus.wr && bus.addr == `DPL_OFS_MASK) |=> !irq)
        else $error("masked interrupt");
endmodule
bind dpl_lock_detect dpl_lock_detect_properties #(.TICK_CYC(TICK_CYC), .QUAL_TICKS(QUAL_TICKS),
    .FINE_STEP(FINE_STEP)) i_props (.mclk(mclk), .rst(rst), .bus(bus), .phase(phase), .rdata(rdata),
    .phase_lock(phase_lock), .phase_loss(phase_loss), .irq(irq));

// *** sim/dpl_loop_model.sv ***
// Loop side model that feeds phase samples to the detector.
// Assumes calls start just after a rising mclk edge.
`timescale 1ns/1ps
module dpl_loop_model
    import dpl_pkg::*;
(
    input  wire logic          mclk,
    output dpl_pkg::dpl_phase_t phase
);
    initial phase = '0;
    // One sample a call; idle lines flip so a stale value never passes as data
    task automatic send(input logic [11:0] f, input logic [7:0] u);
        phase <= '{1'b1, f, u};
        @(posedge mclk);
        phase <= '{1'b0, ~f, ~u};
        #1;
    endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the phase lock and loss detector.
// Assumes short qualification parameters: 3 ticks of 4 cycles.
`timescale 1ns/1ps
module tb_top;
    import dpl_pkg::*;
    logic       mclk;
    logic       rst;
    dpl_bus_t   bus;
    dpl_phase_t phase;
    logic [7:0] rdata;
    logic       phase_lock;
    logic       phase_loss;
    logic       irq;
    int         fails;
    int         check_count;
    int         c;
    dpl_lock_detect #(.TICK_CYC(24'h000004), .QUAL_TICKS(16'h0003), .FINE_STEP(12'h200)) i_dut (.mclk(mclk),
        .rst(rst), .bus(bus), .phase(phase), .rdata(rdata), .phase_lock(phase_lock),
        .phase_loss(phase_loss), .irq(irq));
    dpl_loop_model i_loop (.mclk(mclk), .phase(phase));
    // ==========================================
    // Clock and shared tasks
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        check("rdata", rdata, e);
    endtask
    task automatic samp(input logic [11:0] f, input logic [7:0] u, input logic e);
        i_loop.send(f, u);
        check("phase_loss", {7'h0, phase_loss}, {7'h0, e});
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // Tests; the narrow window bit stays set in every fine write
    initial begin
        bus = '0;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        rd(8'h73, 8'hA2);
        rd(8'h74, 8'h85);
        rd(8'h76, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h73, 8'hBF);
        rd(8'h73, 8'hA7);
        wr(8'h74, 8'hFF);
        rd(8'h74, 8'hEF);
        wr(8'h74, 8'h85);
        wr(8'h73, 8'hA2);
        wr(8'h75, 8'h07);
        rd(8'h75, 8'h00);
        wr(8'h76, 8'h01);
        // Lock stays low through twelve in-window cycles and rises right after them
        repeat (12) i_loop.send(12'h000, 8'h00);
        check("phase_lock", {7'h0, phase_lock}, 8'h00);
        i_loop.send(12'h000, 8'h00);
        check("phase_lock", {7'h0, phase_lock}, 8'h01);
        check("irq", {7'h0, irq}, 8'h01);
        rd(8'h75, 8'h01);
        samp(12'h401, 8'h00, 1'b1);
        check("phase_lock", {7'h0, phase_lock}, 8'h00);
        rd(8'h75, 8'h03);
        wr(8'h75, 8'h01);
        @(posedge mclk);
        #1;
        check("irq", {7'h0, irq}, 8'h00);
        rd(8'h75, 8'h02);
        wr(8'h75, 8'h02);
        // Window edges for each usable code that fits the sample range
        for (c = 1; c <= 3; c++) begin
            wr(8'h73, 8'hA0 | 8'(c));
            samp(12'(c * 512), 8'h00, 1'b0);
            samp(12'(c * 512 + 1), 8'h00, 1'b1);
            samp(12'(-c * 512), 8'h00, 1'b0);
        end
        wr(8'h73, 8'h22);
        samp(12'h7FF, 8'h00, 1'b0);
        wr(8'h73, 8'hA7);
        for (c = 5; c <= 15; c += 10) begin
            wr(8'h74, 8'h80 | 8'(c));
            samp(12'h000, 8'(c), 1'b0);
            samp(12'h000, 8'(c + 1), 1'b1);
        end
        // Coarse loss shows in the state word and sticky status, and reaches irq once unmasked
        rd(8'h77, 8'h0A);
        rd(8'h75, 8'h06);
        wr(8'h76, 8'h04);
        check("irq", {7'h0, irq}, 8'h01);
        wr(8'h74, 8'h0F);
        samp(12'h000, 8'hFF, 1'b0);
        // Reset in mid-run must bring the fine, coarse and mask registers back to their reset images
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        rd(8'h73, 8'hA2);
        rd(8'h74, 8'h85);
        rd(8'h76, 8'h00);
        check("phase_lock", {7'h0, phase_lock}, 8'h00);
        check("irq", {7'h0, irq}, 8'h00);
        end_sim();
    end
    // Watchdog well past the fewer than one hundred cycles the tests need
    initial begin
        repeat (2000) @(posedge mclk);
        fails++;
        end_sim();
    end
endmodule
